/* File: adc_seq_pkg.sv */
// Register map, field layout and reset values of the channel setup sequencer
package adc_seq_pkg;
    localparam int          NUM_CHANNELS   = 16;
    localparam int          NUM_SETUPS     = 8;
    localparam int          ADDR_W         = 6;
    localparam int          DATA_W         = 24;
    // Register addresses (word index on the register strobe port)
    localparam logic [5:0]  ADDR_CONTROL   = 6'h01;
    localparam logic [5:0]  ADDR_MCLK_TALLY = 6'h08;
    localparam logic [5:0]  ADDR_CHAN_BASE = 6'h09;
    localparam logic [5:0]  ADDR_CFG_BASE  = 6'h19;
    localparam logic [5:0]  ADDR_FILT_BASE = 6'h21;
    localparam logic [5:0]  ADDR_OFFS_BASE = 6'h29;
    localparam logic [5:0]  ADDR_GAIN_BASE = 6'h31;
    // Reset values
    localparam logic [15:0] CONTROL_RST    = 16'h0000;
    localparam logic [15:0] CHAN0_RST      = 16'h8001;
    localparam logic [15:0] CHAN_RST       = 16'h0001;
    localparam logic [15:0] CFG_RST        = 16'h0860;
    localparam logic [23:0] FILT_RST       = 24'h060180;
    localparam logic [23:0] OFFS_RST       = 24'h800000;
    localparam logic [7:0]  MCLK_TALLY_RST = 8'h00;
    // Writable masks; unused bits read as zero
    localparam logic [15:0] CONTROL_MASK   = 16'h1fff;
    localparam logic [15:0] CHAN_MASK      = 16'hf3ff;
    localparam logic [15:0] CFG_MASK       = 16'h0fff;
    localparam logic [23:0] FILT_MASK      = 24'hfff7ff;
    // Channel word fields
    localparam int          CH_EN_BIT      = 15;
    localparam int          CH_SETUP_LSB   = 12;
    localparam int          CH_POS_LSB     = 5;
    localparam int          CH_NEG_LSB     = 0;
    // Configuration word fields
    localparam int          CFG_GAIN_LSB   = 0;
    localparam int          CFG_BUFN_BIT   = 5;
    localparam int          CFG_BUFP_BIT   = 6;
    // Gain codes bounding the amplifier stage use
    localparam logic [2:0]  GAIN_CODE_ONE  = 3'h0;
    localparam logic [2:0]  GAIN_CODE_EIGHT = 3'h3;
endpackage : adc_seq_pkg

/* File: next_channel_finder.sv */
// Finds the next enabled channel above the current one, wrapping around
`timescale 1ns/100ps
module next_channel_finder
    import adc_seq_pkg::*;
#(
    parameter int N = NUM_CHANNELS
) (
    input  wire logic [N-1:0]         chanEnable,
    input  wire logic [$clog2(N)-1:0] current,
    output logic      [$clog2(N)-1:0] nextChan,
    output logic                      anyEnabled
);
    localparam int IW = $clog2(N);

    // Search from current+N down to current+1 so the nearest ascending one wins
    always_comb begin
        logic [IW-1:0] cand;
        cand       = current;
        nextChan   = current;
        anyEnabled = |chanEnable;
        for (int step = N; step >= 1; step--) begin
            cand = IW'(int'(current) + step);
            if (chanEnable[cand]) begin
                nextChan = cand;
            end
        end
    end
endmodule : next_channel_finder

/* File: adc_channel_setup_sequencer.sv */
// Channel select, setup assignment and sequencing for a multiplexed converter
// Function
// - Only channel words with enable bit set join the conversion sequence.
// - Enabled channels are visited in ascending index order, wrapping forever.
// - Eight setups of configuration, filter, gain and offset; channels pick one.
// - Each channel word holds five-bit positive and negative input selectors.
// - Any input pin may be positive or negative, any pairing allowed.
// - Finished calibration writes its coefficient into the active channel's setup.
// - Gain field chooses one of eight power-of-two gains, one to 128.
// - Gain one bypasses both stages, two to eight first only, above both.
// - Any gain above one forces both input buffers on.
// - At gain one each input buffer follows its own enable bit.
// - Master clock tally counts clock pulses with clkEn high for oscillator checking.
// - Offset coefficients reset to 0x800000, replaced by host write or calibration.
`timescale 1ns/100ps
module adc_channel_setup_sequencer
    import adc_seq_pkg::*;
#(
    parameter logic [23:0] GAIN_RST = 24'h500000   // Arbitrary factory trim stand-in
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    input  wire logic [5:0]  regAddr,
    input  wire logic [23:0] regWrData,
    input  wire logic        convDone,
    input  wire logic        calDone,
    input  wire logic        calIsGain,
    input  wire logic [23:0] calCoeff,
    output logic      [23:0] regRdData,
    output logic             regRdValid,
    output logic      [3:0]  activeChannel,
    output logic      [2:0]  activeSetup,
    output logic      [4:0]  positive_input_selector,
    output logic      [4:0]  negative_input_selector,
    output logic      [2:0]  amplifier_gain_select,
    output logic             stageOneOn,
    output logic             stageTwoOn,
    output logic             positive_input_buffer_on,
    output logic             negative_input_buffer_on,
    output logic      [23:0] activeOffset,
    output logic      [23:0] activeGain,
    output logic             sequenceActive
);
    localparam int NC = NUM_CHANNELS;
    localparam int NS = NUM_SETUPS;

    // Register storage, all flip-flops
    logic [15:0] control_r, control_nxt;
    logic [7:0]  mclkTally_r, mclkTally_nxt;
    logic [15:0] chan_r   [NC];
    logic [15:0] chan_nxt [NC];
    logic [15:0] cfg_r    [NS];
    logic [15:0] cfg_nxt  [NS];
    logic [23:0] filt_r   [NS];
    logic [23:0] filt_nxt [NS];
    logic [23:0] offs_r   [NS];
    logic [23:0] offs_nxt [NS];
    logic [23:0] gain_r   [NS];
    logic [23:0] gain_nxt [NS];
    logic [23:0] rdData_r, rdData_nxt;
    logic        rdValid_r, rdValid_nxt;

    // Sequencer and derived output state
    logic [3:0]  cur_r, cur_nxt;
    logic [NC-1:0] chanEnable;
    logic [3:0]  nextChan;
    logic        anyEnabled;
    logic [2:0]  curSetup;
    logic [15:0] curCfg;
    logic [2:0]  curGainCode;
    logic [3:0]  actCh_r;
    logic [2:0]  actSetup_r;
    logic [4:0]  posSel_r, negSel_r;
    logic [2:0]  gainSel_r;
    logic        st1_r, st2_r, bufP_r, bufN_r, seqAct_r;
    logic [23:0] actOffs_r, actGain_r;
    logic [3:0]  actCh_nxt;
    logic [2:0]  actSetup_nxt, gainSel_nxt;
    logic [4:0]  posSel_nxt, negSel_nxt;
    logic        st1_nxt, st2_nxt, bufP_nxt, bufN_nxt, seqAct_nxt;
    logic [23:0] actOffs_nxt, actGain_nxt;

    // Enable bits gathered per channel
    for (genvar c = 0; c < NC; c++) begin : g_en
        assign chanEnable[c] = chan_r[c][CH_EN_BIT];
    end

    next_channel_finder #(.N(NC)) u_finder (
        .chanEnable (chanEnable),
        .current    (cur_r),
        .nextChan   (nextChan),
        .anyEnabled (anyEnabled)
    );

    assign curSetup    = chan_r[cur_r][CH_SETUP_LSB +: 3];
    assign curCfg      = cfg_r[curSetup];
    assign curGainCode = curCfg[CFG_GAIN_LSB +: 3];

    // Register writes, calibration updates and the master clock tally
    always_comb begin
        logic [5:0] rel;
        rel           = '0;
        control_nxt   = control_r;
        mclkTally_nxt = mclkTally_r + 8'h01;
        chan_nxt      = chan_r;
        cfg_nxt       = cfg_r;
        filt_nxt      = filt_r;
        offs_nxt      = offs_r;
        gain_nxt      = gain_r;
        if (regWrEn) begin
            if (regAddr == ADDR_CONTROL) begin
                control_nxt = regWrData[15:0] & CONTROL_MASK;
            end else if (regAddr >= ADDR_CHAN_BASE && regAddr < ADDR_CFG_BASE) begin
                rel = regAddr - ADDR_CHAN_BASE;
                chan_nxt[rel[3:0]] = regWrData[15:0] & CHAN_MASK;
            end else if (regAddr >= ADDR_CFG_BASE && regAddr < ADDR_FILT_BASE) begin
                rel = regAddr - ADDR_CFG_BASE;
                cfg_nxt[rel[2:0]] = regWrData[15:0] & CFG_MASK;
            end else if (regAddr >= ADDR_FILT_BASE && regAddr < ADDR_OFFS_BASE) begin
                rel = regAddr - ADDR_FILT_BASE;
                filt_nxt[rel[2:0]] = regWrData & FILT_MASK;
            end else if (regAddr >= ADDR_OFFS_BASE && regAddr < ADDR_GAIN_BASE) begin
                rel = regAddr - ADDR_OFFS_BASE;
                offs_nxt[rel[2:0]] = regWrData;
            end else if (regAddr >= ADDR_GAIN_BASE && regAddr < ADDR_GAIN_BASE + 6'h08) begin
                rel = regAddr - ADDR_GAIN_BASE;
                gain_nxt[rel[2:0]] = regWrData;
            end
        end
        // Calibration result lands after the host write so it wins a collision
        if (calDone) begin
            if (calIsGain) begin
                gain_nxt[curSetup] = calCoeff;
            end else begin
                offs_nxt[curSetup] = calCoeff;
            end
        end
    end

    // Register read port, one cycle latency, unmapped reads give zero
    always_comb begin
        logic [5:0] rel;
        rel         = '0;
        rdValid_nxt = regRdEn;
        rdData_nxt  = rdData_r;
        if (regRdEn) begin
            rdData_nxt = '0;
            if (regAddr == ADDR_CONTROL) begin
                rdData_nxt = {8'h00, control_r};
            end else if (regAddr == ADDR_MCLK_TALLY) begin
                rdData_nxt = {16'h0000, mclkTally_r};
            end else if (regAddr >= ADDR_CHAN_BASE && regAddr < ADDR_CFG_BASE) begin
                rel = regAddr - ADDR_CHAN_BASE;
                rdData_nxt = {8'h00, chan_r[rel[3:0]]};
            end else if (regAddr >= ADDR_CFG_BASE && regAddr < ADDR_FILT_BASE) begin
                rel = regAddr - ADDR_CFG_BASE;
                rdData_nxt = {8'h00, cfg_r[rel[2:0]]};
            end else if (regAddr >= ADDR_FILT_BASE && regAddr < ADDR_OFFS_BASE) begin
                rel = regAddr - ADDR_FILT_BASE;
                rdData_nxt = filt_r[rel[2:0]];
            end else if (regAddr >= ADDR_OFFS_BASE && regAddr < ADDR_GAIN_BASE) begin
                rel = regAddr - ADDR_OFFS_BASE;
                rdData_nxt = offs_r[rel[2:0]];
            end else if (regAddr >= ADDR_GAIN_BASE && regAddr < ADDR_GAIN_BASE + 6'h08) begin
                rel = regAddr - ADDR_GAIN_BASE;
                rdData_nxt = gain_r[rel[2:0]];
            end
        end
    end

    // Sequencer: step on each finished conversion; leave a channel that was disabled at once
    always_comb begin
        cur_nxt = cur_r;
        if (anyEnabled && (convDone || !chanEnable[cur_r])) begin
            cur_nxt = nextChan;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            control_r   <= CONTROL_RST;
            mclkTally_r <= MCLK_TALLY_RST;
            rdData_r    <= '0;
            rdValid_r   <= 1'b0;
            cur_r       <= '0;
            for (int c = 0; c < NC; c++) begin
                chan_r[c] <= (c == 0) ? CHAN0_RST : CHAN_RST;
            end
            for (int s = 0; s < NS; s++) begin
                cfg_r[s]  <= CFG_RST;
                filt_r[s] <= FILT_RST;
                offs_r[s] <= OFFS_RST;
                gain_r[s] <= GAIN_RST;
            end
        end else if (clkEn) begin
            control_r   <= control_nxt;
            mclkTally_r <= mclkTally_nxt;
            rdData_r    <= rdData_nxt;
            rdValid_r   <= rdValid_nxt;
            cur_r       <= cur_nxt;
            chan_r      <= chan_nxt;
            cfg_r       <= cfg_nxt;
            filt_r      <= filt_nxt;
            offs_r      <= offs_nxt;
            gain_r      <= gain_nxt;
        end
    end

    // Input front-end steering values, taken from the channel now selected
    always_comb begin
        actCh_nxt    = cur_r;
        actSetup_nxt = curSetup;
        posSel_nxt   = chan_r[cur_r][CH_POS_LSB +: 5];
        negSel_nxt   = chan_r[cur_r][CH_NEG_LSB +: 5];
        gainSel_nxt  = curGainCode;
        st1_nxt      = curGainCode != GAIN_CODE_ONE;
        st2_nxt      = curGainCode > GAIN_CODE_EIGHT;
        // Gain above one needs the buffers ahead of the amplifier
        bufP_nxt     = (curGainCode != GAIN_CODE_ONE) || curCfg[CFG_BUFP_BIT];
        bufN_nxt     = (curGainCode != GAIN_CODE_ONE) || curCfg[CFG_BUFN_BIT];
        actOffs_nxt  = offs_r[curSetup];
        actGain_nxt  = gain_r[curSetup];
        seqAct_nxt   = chanEnable[cur_r];
    end

    // Steering registered so the mux and amplifier see clean levels
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            actCh_r    <= '0;
            actSetup_r <= '0;
            posSel_r   <= '0;
            negSel_r   <= '0;
            gainSel_r  <= '0;
            st1_r      <= 1'b0;
            st2_r      <= 1'b0;
            bufP_r     <= 1'b0;
            bufN_r     <= 1'b0;
            actOffs_r  <= '0;
            actGain_r  <= '0;
            seqAct_r   <= 1'b0;
        end else if (clkEn) begin
            actCh_r    <= actCh_nxt;
            actSetup_r <= actSetup_nxt;
            posSel_r   <= posSel_nxt;
            negSel_r   <= negSel_nxt;
            gainSel_r  <= gainSel_nxt;
            st1_r      <= st1_nxt;
            st2_r      <= st2_nxt;
            bufP_r     <= bufP_nxt;
            bufN_r     <= bufN_nxt;
            actOffs_r  <= actOffs_nxt;
            actGain_r  <= actGain_nxt;
            seqAct_r   <= seqAct_nxt;
        end
    end

    assign regRdData                = rdData_r;
    assign regRdValid               = rdValid_r;
    assign activeChannel            = actCh_r;
    assign activeSetup              = actSetup_r;
    assign positive_input_selector  = posSel_r;
    assign negative_input_selector  = negSel_r;
    assign amplifier_gain_select    = gainSel_r;
    assign stageOneOn               = st1_r;
    assign stageTwoOn               = st2_r;
    assign positive_input_buffer_on = bufP_r;
    assign negative_input_buffer_on = bufN_r;
    assign activeOffset             = actOffs_r;
    assign activeGain               = actGain_r;
    assign sequenceActive           = seqAct_r;
endmodule : adc_channel_setup_sequencer

/* File: adc_channel_setup_sequencer_chk.sv */
// Port-level assertions for the channel setup sequencer
`timescale 1ns/100ps
module adc_channel_setup_sequencer_chk
    import adc_seq_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        clkEn,
    input wire logic        regRdEn,
    input wire logic [5:0]  regAddr,
    input wire logic [23:0] regRdData,
    input wire logic        regRdValid,
    input wire logic [3:0]  activeChannel,
    input wire logic [2:0]  amplifier_gain_select,
    input wire logic        stageOneOn,
    input wire logic        stageTwoOn,
    input wire logic        positive_input_buffer_on,
    input wire logic        negative_input_buffer_on
);
    // One clock domain, all checks muted during reset
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Read port answers exactly one cycle after the strobe
    property p_rd_ans; regRdEn && clkEn |=> regRdValid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_rd_one; clkEn && !regRdEn |=> !regRdValid; endproperty
    a_rd_one: assert property (p_rd_one) else $error("stray read valid");
    property p_rd_hold; clkEn && !regRdEn |=> $stable(regRdData); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_unmapped; regRdEn && clkEn && regAddr > 6'h38 |=> regRdData == 24'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // Amplifier stages and forced buffers follow the gain code
    property p_stage1; stageOneOn == (amplifier_gain_select != GAIN_CODE_ONE); endproperty
    a_stage1: assert property (p_stage1) else $error("first stage wrong");
    property p_stage2; stageTwoOn == (amplifier_gain_select > GAIN_CODE_EIGHT); endproperty
    a_stage2: assert property (p_stage2) else $error("second stage wrong");
    property p_buf;
        amplifier_gain_select != GAIN_CODE_ONE |-> positive_input_buffer_on && negative_input_buffer_on;
    endproperty
    a_buf: assert property (p_buf) else $error("buffers not forced on");
    // Clock enable low must freeze the active channel and the amplifier gain select
    property p_freeze; !clkEn |=> $stable(activeChannel) && $stable(amplifier_gain_select); endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule : adc_channel_setup_sequencer_chk

bind adc_channel_setup_sequencer adc_channel_setup_sequencer_chk chk (
    .clk                      (clk),
    .rst_n                    (rst_n),
    .clkEn                    (clkEn),
    .regRdEn                  (regRdEn),
    .regAddr                  (regAddr),
    .regRdData                (regRdData),
    .regRdValid               (regRdValid),
    .activeChannel            (activeChannel),
    .amplifier_gain_select    (amplifier_gain_select),
    .stageOneOn               (stageOneOn),
    .stageTwoOn               (stageTwoOn),
    .positive_input_buffer_on (positive_input_buffer_on),
    .negative_input_buffer_on (negative_input_buffer_on)
);

/* File: host_model.sv */
// Host processor model driving the register strobe port
`timescale 1ns/100ps
module host_model (
    input  wire logic        clk,
    input  wire logic [23:0] regRdData,
    input  wire logic        regRdValid,
    output logic             regWrEn,
    output logic             regRdEn,
    output logic      [5:0]  regAddr,
    output logic      [23:0] regWrData
);
    // Idle port; coefficients stay unwritten unless a test asks
    initial begin
        regWrEn   = 1'b0;
        regRdEn   = 1'b0;
        regAddr   = 6'h00;
        regWrData = 24'h0;
    end

    // Write strobe held until the taking edge, stale data scrambled after
    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        @(posedge clk);
        regWrEn   <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clk);
        regWrEn   <= 1'b0;
        regWrData <= ~d;
    endtask : wr

    // Read; data taken only when valid shows, else unknown forces a mismatch
    task automatic rd(input logic [5:0] a, output logic [23:0] d);
        @(posedge clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        d = regRdValid ? regRdData : 24'hxxxxxx;
    endtask : rd
endmodule : host_model

/* File: adc_channel_setup_sequencer_tb.sv */
// Self-checking bench for the channel setup sequencer
`timescale 1ns/100ps
module adc_channel_setup_sequencer_tb;
    import adc_seq_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, convDone = 1'b0, calDone = 1'b0, calIsGain = 1'b0;
    logic        regWrEn, regRdEn, regRdValid, stageOneOn, stageTwoOn, sequenceActive;
    logic        positive_input_buffer_on, negative_input_buffer_on;
    logic [2:0]  activeSetup, amplifier_gain_select;
    logic [3:0]  activeChannel;
    logic [4:0]  positive_input_selector, negative_input_selector;
    logic [5:0]  regAddr;
    logic [23:0] calCoeff = 24'h0, regWrData, regRdData, activeOffset, activeGain, rdVal, rdOld;
    int          nErrors = 0, totalChecks = 0, cycles = 0;
    wire  [6:0]  ampState = {amplifier_gain_select, stageOneOn, stageTwoOn,
                             positive_input_buffer_on, negative_input_buffer_on};

    adc_channel_setup_sequencer dut (
        .clk                      (clk),
        .rst_n                    (rst_n),
        .clkEn                    (clkEn),
        .regWrEn                  (regWrEn),
        .regRdEn                  (regRdEn),
        .regAddr                  (regAddr),
        .regWrData                (regWrData),
        .convDone                 (convDone),
        .calDone                  (calDone),
        .calIsGain                (calIsGain),
        .calCoeff                 (calCoeff),
        .regRdData                (regRdData),
        .regRdValid               (regRdValid),
        .activeChannel            (activeChannel),
        .activeSetup              (activeSetup),
        .positive_input_selector  (positive_input_selector),
        .negative_input_selector  (negative_input_selector),
        .amplifier_gain_select    (amplifier_gain_select),
        .stageOneOn               (stageOneOn),
        .stageTwoOn               (stageTwoOn),
        .positive_input_buffer_on (positive_input_buffer_on),
        .negative_input_buffer_on (negative_input_buffer_on),
        .activeOffset             (activeOffset),
        .activeGain               (activeGain),
        .sequenceActive           (sequenceActive)
    );
    host_model host (
        .clk        (clk),
        .regRdData  (regRdData),
        .regRdValid (regRdValid),
        .regWrEn    (regWrEn),
        .regRdEn    (regRdEn),
        .regAddr    (regAddr),
        .regWrData  (regWrData)
    );

    // Clock and a hang guard far above the expected run
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            nErrors++;
            end_sim();
        end
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        totalChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Outputs trail register state by one edge, so look just after it
    task automatic look();
        @(posedge clk);
        #1;
    endtask : look

    task automatic conv();
        @(posedge clk);
        convDone <= 1'b1;
        @(posedge clk);
        convDone <= 1'b0;
        look();
    endtask : conv

    task automatic steer(input logic [3:0] ch, input logic [2:0] su, input logic [4:0] p, input logic [4:0] n);
        chk({activeChannel, activeSetup, positive_input_selector, negative_input_selector}, {ch, su, p, n});
    endtask : steer

    task automatic t_rst();
        logic [5:0]  a [6] = '{6'h01, 6'h09, 6'h0a, 6'h19, 6'h30, 6'h3f};
        logic [23:0] e [6] = '{24'h0, 24'h8001, 24'h1, 24'h0860, 24'h800000, 24'h0};
        look();
        chk({positive_input_buffer_on, negative_input_buffer_on, sequenceActive}, 3'h7);
        chk(activeOffset, 24'h800000);
        for (int i = 0; i < 6; i++) begin
            host.rd(a[i], rdVal);
            chk(rdVal, e[i]);
        end
        host.rd(ADDR_MCLK_TALLY, rdOld);
        host.rd(ADDR_MCLK_TALLY, rdVal);
        chk(rdVal, {16'h0, rdOld[7:0] + 8'h02});
        $display("reset test done");
    endtask : t_rst

    // Channels 0, 2, 5 enabled; 3 carries fields but no enable
    task automatic t_seq();
        host.wr(ADDR_CFG_BASE + 6'h1, 24'h000040);
        host.wr(ADDR_CFG_BASE + 6'h2, 24'h000005);
        host.wr(ADDR_CHAN_BASE + 6'h2, 24'h009066);
        host.wr(ADDR_CHAN_BASE + 6'h3, 24'h0000e0);
        host.wr(ADDR_CHAN_BASE + 6'h5, 24'h00a0e0);
        conv();
        steer(4'h2, 3'h1, 5'h03, 5'h06);
        chk(ampState, 7'h02);
        conv();
        steer(4'h5, 3'h2, 5'h07, 5'h00);
        chk(ampState, 7'h5f);
        conv();
        steer(4'h0, 3'h0, 5'h00, 5'h01);
        $display("sequence test done");
    endtask : t_seq

    task automatic t_gain();
        for (int g = 0; g < 8; g++) begin
            host.wr(ADDR_CFG_BASE, 24'(g));
            look();
            chk(ampState, {3'(g), g != 0, g > 3, g != 0, g != 0});
        end
        $display("gain test done");
    endtask : t_gain

    // Only channel 5 left; a frozen spell must not disturb it
    task automatic t_one();
        host.wr(ADDR_CHAN_BASE, 24'h000001);
        host.wr(ADDR_CHAN_BASE + 6'h2, 24'h001066);
        host.rd(ADDR_MCLK_TALLY, rdOld);
        @(posedge clk);
        clkEn <= 1'b0;
        repeat (3) @(posedge clk);
        clkEn <= 1'b1;
        // Three frozen edges between the two samples must not count
        host.rd(ADDR_MCLK_TALLY, rdVal);
        chk(rdVal, {16'h0, rdOld[7:0] + 8'h03});
        for (int i = 0; i < 3; i++) begin
            conv();
            steer(4'h5, 3'h2, 5'h07, 5'h00);
        end
        $display("single channel test done");
    endtask : t_one

    // Offset then gain calibration back to back on setup 2
    task automatic t_cal();
        @(posedge clk);
        calDone   <= 1'b1;
        calCoeff  <= 24'h123456;
        @(posedge clk);
        calIsGain <= 1'b1;
        calCoeff  <= 24'h654321;
        @(posedge clk);
        calDone   <= 1'b0;
        host.rd(ADDR_OFFS_BASE + 6'h2, rdVal);
        chk(rdVal, 24'h123456);
        host.rd(ADDR_GAIN_BASE + 6'h2, rdVal);
        chk(rdVal, 24'h654321);
        chk(activeOffset, 24'h123456);
        chk(activeGain, 24'h654321);
        host.wr(ADDR_OFFS_BASE + 6'h2, 24'h0abcde);
        host.rd(ADDR_OFFS_BASE + 6'h2, rdVal);
        chk(rdVal, 24'h0abcde);
        $display("calibration test done");
    endtask : t_cal

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", totalChecks, nErrors);
        if (nErrors == 0 && totalChecks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_rst();
        t_seq();
        t_gain();
        t_one();
        t_cal();
        end_sim();
    end
endmodule : adc_channel_setup_sequencer_tb
